// ---- shared/idl_consts.vh ----
// Constants for the interval data logger control block
`ifndef IDL_CONSTS_VH
`define IDL_CONSTS_VH
// Register byte offsets
`define IDL_OFS_CTRL      6'h00
`define IDL_OFS_CHSEL     6'h04
`define IDL_OFS_KEY_RDR   6'h08
`define IDL_OFS_KEY_DEV   6'h0c
`define IDL_OFS_TIME      6'h10
`define IDL_OFS_RDONE     6'h14
`define IDL_OFS_DATE      6'h18
`define IDL_OFS_PERIOD    6'h1c
`define IDL_OFS_WEIGHT    6'h20
`define IDL_OFS_DAYBND    6'h24
`define IDL_OFS_IDSEL     6'h28
`define IDL_OFS_IDLO      6'h2c
`define IDL_OFS_IDHI      6'h30
`define IDL_OFS_CMD       6'h34
`define IDL_OFS_MISC      6'h38
`define IDL_OFS_LSTAT     6'h3c
// Control bits
`define IDL_CTRL_START    0
`define IDL_CTRL_FIXMARK  1
`define IDL_CTRL_CALOPEN  2
// Corrector fault input bit positions
`define IDL_F_NEWSTART    0
`define IDL_F_POWER       1
`define IDL_F_INCONS      2
`define IDL_F_MEMORY      3
`define IDL_F_CNT_POWER   4
`define IDL_F_CNT1_FREQ   5
`define IDL_F_CNT2_FREQ   6
`define IDL_F_CNT1_DIST   7
`define IDL_F_CNT2_DIST   8
`define IDL_F_CNT1_SUSP   9
`define IDL_F_CNT2_SUSP   10
`define IDL_F_MAXFLOW     11
`define IDL_F_P_DIST      12
`define IDL_F_P_CAL       13
`define IDL_F_P_CORR      14
`define IDL_F_T_DIST      15
`define IDL_F_T_CAL       16
`define IDL_F_T_CORR      17
`define IDL_FAULT_W       18
// Values
`define IDL_SEL_FIRST     8'd21
`define IDL_SEL_LAST      8'd24
`define IDL_MAX_PULSES    13'd4079
`define IDL_DAYBND_RST    5'd6
`define IDL_PERIOD_RST    6'd60
`define IDL_WEIGHT_RST    3'd2
`define IDL_WEIGHT_MAX    3'd4
`define IDL_DAY_RST       5'd1
`define IDL_MONTH_RST     4'd1
`define IDL_YEAR_RST      8'd88
`define IDL_CMD_ADJCNT    8'd75
`define IDL_CMD_UNIT      8'd20
`define IDL_CMD_CPZ       8'd7
`define IDL_CLK_HZ        25000000
`define IDL_TICK_S        1
`define IDL_RESP_OKAY     2'b00
`define IDL_RESP_SLVERR   2'b10
`endif

// ---- hw/idl_logger_ctrl.v ----
// Interval data logger control with AXI4-Lite register slave
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "idl_consts.vh"
module idl_logger_ctrl #(
  parameter TICK_CYCLES = `IDL_CLK_HZ * `IDL_TICK_S
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [17:0] vc_fault,
  input  wire        vc_fault_ack,
  input  wire        vol_pulse,
  input  wire        std_pulse,
  output reg         rec_valid,
  output reg  [19:0] rec_tags,
  output reg         rec_mark,
  output reg         rec_overflow,
  output reg  [2:0]  rec_weight,
  output reg  [12:0] rec_vol_count,
  output reg  [12:0] rec_std_count,
  output reg         day_start,
  output reg         readout_active,
  output reg  [1:0]  logger_channel_index,
  output wire        interval_overflow_warning
);

  // Bus handshake state
  reg        aw_full_reg;
  reg [5:0]  aw_addr_reg;
  reg        w_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  wire       wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  // Configuration and state
  reg        clock_set_reg;
  reg        cal_open_reg;
  reg [2:0]  sel_reg;
  reg [31:0] key_rdr_reg;
  reg [31:0] key_dev_reg;
  reg [5:0]  sec_reg;
  reg [5:0]  min_reg;
  reg [4:0]  hour_reg;
  reg [4:0]  day_reg;
  reg [3:0]  month_reg;
  reg [7:0]  year_reg;
  reg [5:0]  period_reg;
  reg [5:0]  period_pend_reg;
  reg [5:0]  ivl_min_reg;
  reg [2:0]  weight_reg;
  reg [2:0]  weight_pend_reg;
  reg [4:0]  daybnd_reg;
  reg [3:0]  idsel_reg;
  reg [31:0] idlo_stage_reg;
  reg [47:0] id_mem [0:11];
  reg        mark_pend_reg;
  reg        unknown_cmd_reg;
  reg [7:0]  bad_cmd_reg;
  reg [12:0] vol_cnt_reg;
  reg [12:0] std_cnt_reg;
  reg        ovf_reg;
  reg        ovf_ivl_reg;
  reg [31:0] tick_cnt_reg;
  reg [19:0] tag_reg;
  reg [23:0] stat_reg;
  integer    k;

  wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                       {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] wd = w_data_reg & wmask;
  wire key_ok = (key_dev_reg == 32'h0000_0000) |
                (key_rdr_reg == key_dev_reg);
  wire wr_ctrl   = wr_go & (aw_addr_reg == `IDL_OFS_CTRL);
  wire wr_chsel  = wr_go & (aw_addr_reg == `IDL_OFS_CHSEL);
  wire wr_keyr   = wr_go & (aw_addr_reg == `IDL_OFS_KEY_RDR);
  wire wr_keyd   = wr_go & (aw_addr_reg == `IDL_OFS_KEY_DEV);
  wire wr_time   = wr_go & (aw_addr_reg == `IDL_OFS_TIME);
  wire wr_rdone  = wr_go & (aw_addr_reg == `IDL_OFS_RDONE);
  wire wr_date   = wr_go & (aw_addr_reg == `IDL_OFS_DATE);
  wire wr_period = wr_go & (aw_addr_reg == `IDL_OFS_PERIOD) & key_ok;
  wire wr_weight = wr_go & (aw_addr_reg == `IDL_OFS_WEIGHT) & key_ok;
  wire wr_daybnd = wr_go & (aw_addr_reg == `IDL_OFS_DAYBND) & key_ok;
  wire wr_idsel  = wr_go & (aw_addr_reg == `IDL_OFS_IDSEL);
  wire wr_idlo   = wr_go & (aw_addr_reg == `IDL_OFS_IDLO);
  wire wr_idhi   = wr_go & (aw_addr_reg == `IDL_OFS_IDHI) & key_ok;
  wire wr_cmd    = wr_go & (aw_addr_reg == `IDL_OFS_CMD);
  wire wr_mapped = (aw_addr_reg <= `IDL_OFS_LSTAT) &
                   (aw_addr_reg[1:0] == 2'b00);

  // Fault translation per channel, bit n-1 is status n
  wire cnt_warn = vc_fault[`IDL_F_CNT1_FREQ] | vc_fault[`IDL_F_CNT2_FREQ] |
                  vc_fault[`IDL_F_CNT1_DIST] | vc_fault[`IDL_F_CNT2_DIST] |
                  vc_fault[`IDL_F_CNT1_SUSP] | vc_fault[`IDL_F_CNT2_SUSP] |
                  vc_fault[`IDL_F_MAXFLOW];
  wire p_bad = vc_fault[`IDL_F_P_DIST] | vc_fault[`IDL_F_P_CAL] |
               vc_fault[`IDL_F_P_CORR];
  wire t_bad = vc_fault[`IDL_F_T_DIST] | vc_fault[`IDL_F_T_CAL] |
               vc_fault[`IDL_F_T_CORR];
  wire [23:0] hit;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_map
      wire vol = (g < 2);
      assign hit[g*6]   = vc_fault[`IDL_F_NEWSTART];
      assign hit[g*6+1] = vc_fault[`IDL_F_POWER];
      assign hit[g*6+2] = vol & vc_fault[`IDL_F_CNT_POWER];
      assign hit[g*6+3] = ((g == 1) & (p_bad | t_bad)) |
                          ((g == 2) & p_bad) |
                          ((g == 3) & t_bad);
      assign hit[g*6+4] = vol & cnt_warn;
      assign hit[g*6+5] = vc_fault[`IDL_F_INCONS] |
                          vc_fault[`IDL_F_MEMORY];
    end
  endgenerate

  // Second prescaler and interval timing
  wire tick   = (tick_cnt_reg == TICK_CYCLES - 1);
  wire min_up = tick & (sec_reg == 6'd59);
  wire hr_up  = min_up & (min_reg == 6'd59);
  wire ivl_end = min_up & (ivl_min_reg == period_reg - 6'd1);
  wire [5:0] wp = wd[5:0];
  wire period_ok = (wp == 6'd5) | (wp == 6'd10) | (wp == 6'd15) |
                   (wp == 6'd20) | (wp == 6'd30) | (wp == 6'd60);
  wire store_en = clock_set_reg;
  wire [7:0] cmd = wd[7:0];
  wire [2:0] chsel_idx = wd[2:0] - 3'd5;
  wire clr_ok = vc_fault_ack;
  assign interval_overflow_warning = ovf_reg;

  // Stored data stream and logger status
  always @(posedge aclk) begin
    if (!aresetn) begin
      tag_reg       <= 20'h00000;
      stat_reg      <= 24'h041041;
      rec_valid     <= 1'b0;
      rec_tags      <= 20'h00000;
      rec_mark      <= 1'b0;
      rec_overflow  <= 1'b0;
      rec_weight    <= `IDL_WEIGHT_RST;
      rec_vol_count <= 13'h0000;
      rec_std_count <= 13'h0000;
    end else begin
      rec_valid <= ivl_end & store_en;
      if (ivl_end) begin
        rec_tags      <= tag_reg;
        rec_mark      <= mark_pend_reg;
        rec_overflow  <= ovf_ivl_reg;
        rec_weight    <= weight_reg;
        rec_vol_count <= vol_cnt_reg;
        rec_std_count <= std_cnt_reg;
      end
      for (k = 0; k < 4; k = k + 1) begin
        // Tags gather hits of status 1 to 5 of the interval, not status 6; a hit at the edge survives
        tag_reg[k*5 +: 5] <= (ivl_end ? 5'h00 : tag_reg[k*5 +: 5]) |
                             hit[k*6 +: 5];
        stat_reg[k*6 +: 6] <= ((wr_rdone & readout_active &
                                (logger_channel_index == k[1:0]) &
                                clr_ok) ? 6'h00 : stat_reg[k*6 +: 6]) |
                              hit[k*6 +: 6];
      end
    end
  end

  // Clock, counters and parameters
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg    <= 32'h0000_0000;
      clock_set_reg   <= 1'b0;
      sec_reg         <= 6'h00;
      min_reg         <= 6'h00;
      hour_reg        <= 5'h00;
      day_reg         <= `IDL_DAY_RST;
      month_reg       <= `IDL_MONTH_RST;
      year_reg        <= `IDL_YEAR_RST;
      period_reg      <= `IDL_PERIOD_RST;
      period_pend_reg <= `IDL_PERIOD_RST;
      ivl_min_reg     <= 6'h00;
      weight_reg      <= `IDL_WEIGHT_RST;
      weight_pend_reg <= `IDL_WEIGHT_RST;
      daybnd_reg      <= `IDL_DAYBND_RST;
      key_rdr_reg     <= 32'h0000_0000;
      key_dev_reg     <= 32'h0000_0000;
      cal_open_reg    <= 1'b0;
      sel_reg         <= 3'h0;
      readout_active  <= 1'b0;
      logger_channel_index <= 2'h0;
      idsel_reg       <= 4'h0;
      idlo_stage_reg  <= 32'h0000_0000;
      mark_pend_reg   <= 1'b0;
      unknown_cmd_reg <= 1'b0;
      bad_cmd_reg     <= 8'h00;
      vol_cnt_reg     <= 13'h0000;
      std_cnt_reg     <= 13'h0000;
      ovf_reg         <= 1'b0;
      ovf_ivl_reg     <= 1'b0;
      day_start       <= 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
        id_mem[k] <= 48'h0;
      end
    end else begin
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'd1;
      // Hour 23 wraps to 0 so a midnight boundary still fires
      day_start <= hr_up & (((hour_reg == 5'd23) ? 5'h00 : hour_reg + 5'd1)
                            == daybnd_reg);
      if (tick) begin
        sec_reg <= (sec_reg == 6'd59) ? 6'h00 : sec_reg + 6'd1;
      end
      if (min_up) begin
        min_reg <= (min_reg == 6'd59) ? 6'h00 : min_reg + 6'd1;
        ivl_min_reg <= ivl_end ? 6'h00 : ivl_min_reg + 6'd1;
      end
      if (hr_up) begin
        // Month roll-over is left to software; only the day advances
        hour_reg <= (hour_reg == 5'd23) ? 5'h00 : hour_reg + 5'd1;
        if (hour_reg == 5'd23) begin
          day_reg <= day_reg + 5'd1;
        end
        period_reg  <= period_pend_reg;
        ivl_min_reg <= 6'h00;
      end
      if (ivl_end) begin
        weight_reg <= weight_pend_reg;
      end
      if (wr_time | (wr_rdone & readout_active)) begin
        sec_reg       <= wd[5:0];
        min_reg       <= wd[13:8];
        hour_reg      <= wd[20:16];
        clock_set_reg <= 1'b1;
        tick_cnt_reg  <= 32'h0000_0000;
      end
      if (wr_rdone) begin
        readout_active <= 1'b0;
      end
      if (wr_date) begin
        day_reg   <= wd[4:0];
        month_reg <= wd[11:8];
        year_reg  <= wd[23:16];
      end
      if (wr_ctrl) begin
        cal_open_reg <= wd[`IDL_CTRL_CALOPEN];
        if (wd[`IDL_CTRL_START] & sel_reg[2]) begin
          readout_active       <= 1'b1;
          logger_channel_index <= sel_reg[1:0];
          sel_reg              <= 3'h0;
        end
      end
      if (wr_chsel) begin
        // Only an explicit code picks a channel, nothing else does
        sel_reg <= ((wd[7:0] >= `IDL_SEL_FIRST) &
                    (wd[7:0] <= `IDL_SEL_LAST)) ?
                   {1'b1, chsel_idx[1:0]} : 3'h0;
      end
      if (wr_keyr) begin
        key_rdr_reg <= wd;
      end
      if (wr_keyd & (key_ok | cal_open_reg)) begin
        key_dev_reg <= wd;
      end
      if (wr_period & period_ok) begin
        period_pend_reg <= wp;
      end
      if (wr_weight & (wd[2:0] <= `IDL_WEIGHT_MAX)) begin
        weight_pend_reg <= wd[2:0];
      end
      if (wr_daybnd & (wd[4:0] < 5'd24)) begin
        daybnd_reg <= wd[4:0];
      end
      if (wr_idsel & (wd[3:2] != 2'b11)) begin
        idsel_reg <= wd[3:0];
      end
      if (wr_idlo) begin
        idlo_stage_reg <= wd;
      end
      if (wr_idhi) begin
        // Kind in idsel[3:2]: 0 customer, 1 meter, 2 device
        if (idsel_reg[3:2] == 2'b10) begin
          id_mem[idsel_reg] <= {wd[15:0], idlo_stage_reg[31:20],
                                1'b0, {1'b0, idsel_reg[1:0]} + 3'd1,
                                idlo_stage_reg[15:0]};
        end else begin
          id_mem[idsel_reg] <= {wd[15:0], idlo_stage_reg};
        end
        mark_pend_reg <= 1'b1;
      end else if (wr_ctrl & wd[`IDL_CTRL_FIXMARK] & key_ok) begin
        mark_pend_reg <= 1'b1;
      end else if (ivl_end) begin
        mark_pend_reg <= 1'b0;
      end
      if (wr_cmd) begin
        if ((cmd == `IDL_CMD_ADJCNT) | (cmd == `IDL_CMD_UNIT) |
            (cmd == `IDL_CMD_CPZ)) begin
          unknown_cmd_reg <= 1'b1;
          bad_cmd_reg     <= (cmd == `IDL_CMD_ADJCNT) ?
                             `IDL_CMD_ADJCNT : cmd;
        end else begin
          unknown_cmd_reg <= 1'b0;
        end
      end
      // Saturate at one past the limit so a wrap cannot hide it
      if (ivl_end) begin
        vol_cnt_reg <= {12'h000, vol_pulse};
        std_cnt_reg <= {12'h000, std_pulse};
        ovf_ivl_reg <= 1'b0;
      end else begin
        if (vol_pulse & (vol_cnt_reg <= `IDL_MAX_PULSES)) begin
          vol_cnt_reg <= vol_cnt_reg + 13'd1;
        end
        if (std_pulse & (std_cnt_reg <= `IDL_MAX_PULSES)) begin
          std_cnt_reg <= std_cnt_reg + 13'd1;
        end
        if ((vol_cnt_reg > `IDL_MAX_PULSES) |
            (std_cnt_reg > `IDL_MAX_PULSES)) begin
          ovf_ivl_reg <= 1'b1;
          ovf_reg     <= 1'b1;
        end
      end
      if (wr_rdone & readout_active & clr_ok &
          (vol_cnt_reg <= `IDL_MAX_PULSES) &
          (std_cnt_reg <= `IDL_MAX_PULSES)) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= 6'h00;
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IDL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid & ~w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `IDL_RESP_OKAY : `IDL_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[5:2], 2'b00})
      `IDL_OFS_CTRL:    rd_mux = {29'h0, cal_open_reg, 2'b00};
      `IDL_OFS_CHSEL:   rd_mux = {26'h0, readout_active,
                                  logger_channel_index, sel_reg};
      `IDL_OFS_KEY_RDR: rd_mux = key_rdr_reg;
      `IDL_OFS_KEY_DEV: rd_mux = {31'h0, key_ok};
      `IDL_OFS_TIME:    rd_mux = {11'h0, hour_reg, 2'b00, min_reg,
                                  2'b00, sec_reg};
      `IDL_OFS_RDONE:   rd_mux = 32'h0000_0000;
      `IDL_OFS_DATE:    rd_mux = {8'h0, year_reg, 4'h0, month_reg,
                                  3'h0, day_reg};
      `IDL_OFS_PERIOD:  rd_mux = {18'h0, period_pend_reg, 2'b00,
                                  period_reg};
      `IDL_OFS_WEIGHT:  rd_mux = {21'h0, weight_pend_reg, 5'h0,
                                  weight_reg};
      `IDL_OFS_DAYBND:  rd_mux = {27'h0, daybnd_reg};
      `IDL_OFS_IDSEL:   rd_mux = {28'h0, idsel_reg};
      `IDL_OFS_IDLO:    rd_mux = id_mem[idsel_reg][31:0];
      `IDL_OFS_IDHI:    rd_mux = {16'h0, id_mem[idsel_reg][47:32]};
      `IDL_OFS_CMD:     rd_mux = {23'h0, unknown_cmd_reg, bad_cmd_reg};
      `IDL_OFS_MISC:    rd_mux = {28'h0, mark_pend_reg, ovf_reg,
                                  key_ok, clock_set_reg};
      `IDL_OFS_LSTAT:   rd_mux = {8'h0, stat_reg[23:0]};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `IDL_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? `IDL_RESP_OKAY : `IDL_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // idl_logger_ctrl
`default_nettype wire

// ---- testbench/idl_logger_ctrl_properties.sv ----
// Port assertions for the interval logger control block
`timescale 1ns/1ps
`default_nettype none
module idl_logger_ctrl_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [17:0] vc_fault,
  input wire logic        rec_valid,
  input wire logic [19:0] rec_tags,
  input wire logic        day_start,
  input wire logic        readout_active,
  input wire logic        interval_overflow_warning
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_bresp_okay: assert property (
    s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  a_rresp_okay: assert property (
    s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_reset_quiet: assert property (
    disable iff (1'b0) !aresetn |=> !rec_valid && !readout_active
    && !interval_overflow_warning) else $error("output busy in reset");
  a_vol_only: assert property (
    rec_valid |-> !(rec_tags[12] || rec_tags[17] || rec_tags[14]
    || rec_tags[19])) else $error("volume status on analogue channel");
  a_no_s4_actual: assert property (
    rec_valid |-> !rec_tags[3]) else $error("status 4 on actual volume");
  a_power_tags: assert property (
    rec_valid && $past(vc_fault[1], 3) |-> rec_tags[1] && rec_tags[6]
    && rec_tags[11] && rec_tags[16]) else $error("supply status lost");
  a_rec_spacing: assert property (
    rec_valid |=> !rec_valid [*8]) else $error("records too close");
  a_day_pulse: assert property (
    day_start |=> !day_start [*8]) else $error("day pulse too long");
  c_record: cover property (rec_valid);
  c_readout: cover property ($rose(readout_active));
  c_day: cover property (day_start);
endmodule // idl_logger_ctrl_properties
`default_nettype wire

// ---- testbench/idl_reader.sv ----
// Read-out unit model: AXI4-Lite master for the logger registers
`timescale 1ns/1ps
`default_nettype none
module idl_reader (
  input  wire logic        aclk,
  output var  logic [5:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [5:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // Ready lines stay high: every answer is taken at once
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'b000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_bready, s_axi_rready} = 2'b11;
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
  endtask
endmodule // idl_reader
`default_nettype wire

// ---- testbench/interval_data_logger_control_tb.sv ----
// Self-checking bench for the interval logger control block
`timescale 1ns/1ps
`default_nettype none
`include "idl_consts.vh"
module interval_data_logger_control_tb;
  logic aclk = 0, aresetn = 0, vc_fault_ack = 0, vol_pulse = 0, std_pulse = 0;
  logic [17:0] vc_fault = '0, f1, f2;
  logic [5:0] s_axi_awaddr, s_axi_araddr, p, pp = 6'd60;
  logic [31:0] s_axi_wdata, s_axi_rdata, ls;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, logger_channel_index;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rec_valid, rec_mark, rec_overflow, day_start, readout_active, day_seen;
  logic interval_overflow_warning;
  logic [19:0] rec_tags, tq;
  logic [2:0] rec_weight, wq;
  logic [12:0] rec_vol_count, rec_std_count;
  logic [7:0] cmds [3] = '{8'd75, 8'd20, 8'd7};
  int miscompares = 0, check_count = 0, seed = 75, nrec = 0;
  int nv = 0, ns = 0;
  logic [1:0] p1 = '0, p2 = '0;
  localparam logic [19:0] M = 20'hf7bde;
  idl_logger_ctrl #(.TICK_CYCLES(4)) u_dut (.*);
  idl_reader rdr (.*);
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    // Pulses at the closing edge and the one after belong to the next record
    if (aresetn) begin
      nv += vol_pulse;
      ns += std_pulse;
    end
    p2 = p1;
    p1 = {vol_pulse, std_pulse};
    if (rec_valid) begin
      nrec++;
      tq = rec_tags;
      wq = rec_weight;
      chk(rec_vol_count, nv - p1[1] - p2[1]);
      chk(rec_std_count, ns - p1[0] - p2[0]);
      chk(rec_overflow, 0);
      chk(rec_mark, 0);
      nv = p1[1] + p2[1];
      ns = p1[0] + p2[0];
    end
    if (day_start) day_seen = 1'b1;
    {vol_pulse, std_pulse} <= 2'($random(seed));
  end
  function automatic logic [19:0] exp_tags(input logic [17:0] f);
    logic v3, v5, p4, t4;
    v3 = f[4];
    v5 = |f[11:5];
    p4 = |f[14:12];
    t4 = |f[17:15];
    return {1'b0, t4, 1'b0, f[1:0], 1'b0, p4, 1'b0, f[1:0],
            v5, p4 | t4, v3, f[1:0], v5, 1'b0, v3, f[1:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] m, e);
    logic [31:0] v;
    rdr.rd(a, v);
    chk(v & m, e);
  endtask
  task automatic wait_rec(input int n);
    for (int k = 0; k < 3000 && nrec < n; k++) @(posedge aclk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`IDL_OFS_LSTAT, '1, 32'h41041);
    rc(`IDL_OFS_DATE, 32'hffffff, 32'h580101);
    rc(`IDL_OFS_DAYBND, 32'h1f, 32'd6);
    rc(`IDL_OFS_KEY_DEV, 32'h1, 32'h1);
    rc(`IDL_OFS_MISC, 32'h1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rdr.wr(`IDL_OFS_CMD, {24'd0, cmds[i]});
      rc(`IDL_OFS_CMD, 32'h1ff, {23'd0, 1'b1, cmds[i]});
    end
    for (int i = 0; i < 8; i++) begin
      p = (i == 7) ? 6'd5 : 6'($random(seed));
      if (p inside {5, 10, 15, 20, 30, 60}) pp = p;
      rdr.wr(`IDL_OFS_PERIOD, {26'd0, p});
      rc(`IDL_OFS_PERIOD, 32'h3f3f, {18'd0, pp, 8'd60});
    end
    f1 = 18'($random(seed));
    f1[1] = 1'b1;
    vc_fault <= f1;
    chk(nrec, 0);
    rdr.wr(`IDL_OFS_TIME, 32'h3b32);
    rc(`IDL_OFS_MISC, 32'h1, 32'h1);
    rdr.wr(`IDL_OFS_WEIGHT, 32'd3);
    rc(`IDL_OFS_WEIGHT, 32'h707, 32'h302);
    wait_rec(1);
    chk(tq & M, exp_tags(f1) & M);
    chk(wq, 2);
    rc(`IDL_OFS_PERIOD, 32'h3f, 32'd5);
    repeat (10) @(posedge aclk);
    f2 = 18'($random(seed));
    vc_fault <= f2;
    repeat (600) @(posedge aclk);
    vc_fault <= '0;
    wait_rec(2);
    chk(nrec, 2);
    chk(tq & M, (exp_tags(f1) | exp_tags(f2)) & M);
    chk(wq, 3);
    rdr.rd(`IDL_OFS_LSTAT, ls);
    for (int i = 0; i < 2; i++) begin
      vc_fault_ack <= i[0];
      day_seen = 1'b0;
      rdr.wr(`IDL_OFS_CHSEL, 32'd22);
      rdr.wr(`IDL_OFS_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      chk(readout_active, 1);
      chk(logger_channel_index, 1);
      rdr.wr(`IDL_OFS_RDONE, 32'h53b32);
      repeat (2) @(posedge aclk);
      chk(readout_active, 0);
      rc(`IDL_OFS_LSTAT, 32'hfc0, i ? 32'h0 : ls & 32'hfc0);
    end
    for (int k = 0; k < 100 && !day_seen; k++) @(posedge aclk);
    chk(day_seen, 1);
    rdr.wr(`IDL_OFS_KEY_DEV, 32'h1234);
    rc(`IDL_OFS_KEY_DEV, 32'h1, 32'h0);
    rdr.wr(`IDL_OFS_DAYBND, 32'd9);
    rc(`IDL_OFS_DAYBND, 32'h1f, 32'd6);
    rdr.wr(`IDL_OFS_KEY_DEV, 32'h0);
    rc(`IDL_OFS_KEY_DEV, 32'h1, 32'h0);
    rdr.wr(`IDL_OFS_KEY_RDR, 32'h1234);
    rdr.wr(`IDL_OFS_DAYBND, 32'd9);
    rc(`IDL_OFS_DAYBND, 32'h1f, 32'd9);
    rdr.wr(`IDL_OFS_IDSEL, 32'hb);
    rdr.wr(`IDL_OFS_IDLO, 32'h12305678);
    rdr.wr(`IDL_OFS_IDHI, 32'h9abc);
    rc(`IDL_OFS_IDLO, '1, 32'h12345678);
    rc(`IDL_OFS_IDHI, '1, 32'h9abc);
    rc(`IDL_OFS_MISC, 32'h8, 32'h8);
    rdr.wr(`IDL_OFS_IDSEL, 32'h3);
    rc(`IDL_OFS_IDLO, '1, 32'h0);
    chk(interval_overflow_warning, 0);
    summarize();
  end
  initial begin
    #800000;
    miscompares++;
    summarize();
  end
endmodule // interval_data_logger_control_tb
bind idl_logger_ctrl idl_logger_ctrl_properties u_props (.*);
`default_nettype wire
